// ### common/brc_pkg.sv
// Purpose: Shared constants and types for the boot and reset configuration block.
// Assumes: One 25 MHz clock; test clock is a slow level made by the host end.
// Notes:   Device memory is word addressed over the host port.
package brc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;       // System clock rate.
  localparam int unsigned TCK_DIV = 4;               // Clock cycles per test-clock half period.
  localparam int unsigned HP_AW = 10;                // Host port word address width.
  localparam int unsigned ROM_AW = 10;               // Boot ROM byte address width.
  localparam int unsigned ROM_BYTES = 1024;          // Size of the ROM boot image in bytes.
  localparam int unsigned MEM_WORDS = 256;           // Internal memory words at address 0.
  localparam logic [HP_AW-1:0] HPC_ADDR = 10'h100;   // Host port control register.
  localparam logic [HP_AW-1:0] EMC_ADDR = 10'h101;   // Memory interface configuration register.
  localparam int unsigned HRF_BIT = 1;               // Host-release flag position in the control reg.
  localparam logic [31:0] EMC_RESET = 32'h0000_0000; // Memory interface config after reset.
  localparam logic [7:0] BOOT_PC = 8'h00;            // CPU start address after any boot.
  localparam logic [5:0] PWRD_CLKOUT_HALT = 6'h1A;   // Clock output halt mode code.
  localparam logic [5:0] PWRD_CLKIN_HALT = 6'h1C;    // Clock input halt mode code.
  localparam logic [1:0] EMU_CFG_BSCAN = 2'h0;       // Emulation config code for boundary scan.
  localparam logic [1:0] EMU_CFG_RESET = 2'h3;       // Emulation config code after reset.
  localparam logic [9:0] ROM_LAST = 10'h3FF;         // Last byte index of the boot image.

  // Boot mode strap encoding.
  typedef enum logic [1:0] {
    BRC_BOOT_NONE = 2'h0,
    BRC_BOOT_HOST = 2'h1,
    BRC_BOOT_ROM  = 2'h2,
    BRC_BOOT_RSVD = 2'h3
  } brc_boot_t;
endpackage

// ### common/brc_if.sv
// Purpose: Pins between the device end and the host, ROM and test controller end.
// Assumes: All signals are synchronous to the shared clock.
// Notes:   The test reset wire is resolved here from the host enable and device pull.
`timescale 1ns/1ps
`default_nettype none
interface brc_if;
  import brc_pkg::*;
  logic              reset_n;     // Active-low device reset.
  logic              trst_drv;    // Host drive level of the test reset.
  logic              trst_oe;     // Host drives the test reset when high.
  logic              trst_pd;     // Device weak pull-down on the test reset.
  logic              trst;        // Resolved test reset level, active low.
  logic              tck;         // Test clock level.
  logic [1:0]        boot_mode;   // Boot mode straps.
  logic              pci_sel;     // PCI host select strap.
  logic              little_end;  // System endianness strap, high for little endian.
  logic [1:0]        emu_pins;    // Emulation configuration pins.
  logic              cable;       // Emulator cable present.
  logic              hp_req;      // Host access request, held until acknowledged.
  logic              hp_pci;      // Access arrives on the PCI port when high.
  logic              hp_we;       // Host access is a write.
  logic [HP_AW-1:0]  hp_addr;     // Host word address.
  logic [31:0]       hp_wdata;    // Host write data.
  logic [31:0]       hp_rdata;    // Device read data.
  logic              hp_ack;      // Device acknowledge pulse.
  logic              rom_req;     // ROM byte request from the device.
  logic [ROM_AW-1:0] rom_addr;    // ROM byte address.
  logic [7:0]        rom_data;    // ROM byte.
  logic              rom_ack;     // ROM byte valid pulse.

  // An undriven test reset falls to the weak pull-down level.
  assign trst = trst_oe ? trst_drv : ~trst_pd;

  modport dev (input reset_n, trst, tck, boot_mode, pci_sel, little_end, emu_pins, cable,
               input hp_req, hp_pci, hp_we, hp_addr, hp_wdata, rom_data, rom_ack,
               output trst_pd, hp_rdata, hp_ack, rom_req, rom_addr);
  modport host (output reset_n, trst_drv, trst_oe, tck, boot_mode, pci_sel, little_end,
                output emu_pins, cable, hp_req, hp_pci, hp_we, hp_addr, hp_wdata,
                output rom_data, rom_ack,
                input trst, hp_rdata, hp_ack, rom_req, rom_addr);
endinterface
`default_nettype wire

// ### rtl/brc_device.sv
// Purpose: Device end: reset release, boot sequencing, host release, test reset and halts.
// Assumes: Pins are synchronous to clock_in; the host end answers ROM requests.
// Notes:   Internal memory is a small word array standing for the CPU memory space.
// How it works
// - Device held in reset while reset pin low.
// - Host boot: CPU stalled, rest released.
// - Host reads and writes memory and registers.
// - PCI strap selects which host port boots.
// - Host-release flag ends stall, CPU starts at 0.
// - Releasing flag raises no CPU interrupt.
// - Flag releases stall only in host boot.
// - CPU clears flag; no interrupts until then.
// - ROM boot copies 1K image to 0.
// - ROM bytes packed into 32-bit words.
// - Copy completes, stall released, CPU starts at 0.
// - ROM image stored in system byte order.
// - No boot: CPU runs from 0 at once.
// - Both resets asserted at power up.
// - Test reset sampled on running test clock.
// - Test reset may stay asserted while booting.
// - Variant field valid only out of reset.
// - Weak pull-down on test reset input.
// - Test reset rise latches emulation pins only out of device reset.
// - Emulator attached masks power-down modes.
// - Deep halts make emulator commands spin.
// - Deep halts exit only by device reset.
`timescale 1ns/1ps
`default_nettype none
module brc_device
(
  input  wire logic          clock_in,          // System clock.
  input  wire logic          rst_in,            // Power-on reset, active high.
  brc_if.dev                 pins,              // Link to the host end.
  input  wire logic          cpu_flag_clr_in,   // CPU clears the host-release flag.
  input  wire logic          pwrd_wr_in,        // CPU writes the power-down field.
  input  wire logic [5:0]    pwrd_in,           // Power-down field value.
  input  wire logic          emu_cmd_in,        // Emulator execution command.
  input  wire logic          emu_pc_wr_in,      // Emulator program counter write.
  input  wire logic [7:0]    cpu_fetch_addr_in, // CPU fetch word address.
  output logic               cpu_stall_out,     // CPU held stalled.
  output logic               cpu_start_out,     // Pulse: CPU starts at cpu_start_pc_out.
  output logic [7:0]         cpu_start_pc_out,  // CPU start address.
  output logic [31:0]        cpu_fetch_data_out,// Fetched word.
  output logic               cpu_hrf_irq_out,   // Pulse: host-release interrupt to CPU.
  output logic               hrf_out,           // Host-release flag.
  output logic [5:0]         pwrd_eff_out,      // Power-down field after emulator masking.
  output logic               halted_out,        // Device in a deep halt mode.
  output logic               emu_spin_out,      // Emulator command spins in idle.
  output logic               emu_pc_ok_out,     // Emulator PC write accepted.
  output logic               variant_ok_out,    // Identification variant readable.
  output logic [1:0]         emu_cfg_out,       // Latched emulation configuration.
  output logic               bscan_mode_out,    // Boundary scan mode selected.
  output logic [31:0]        emc_cfg_out        // Memory interface configuration.
);
  import brc_pkg::*;

  typedef enum logic [2:0] {ST_RESET, ST_HOST_STALL, ST_ROM_COPY, ST_RUN, ST_HALT} brc_dst_t;

  brc_dst_t          st_q, st_d;          // Boot sequencer state.
  brc_boot_t         boot_q, boot_d;      // Captured boot mode.
  logic              pci_q, pci_d;        // Captured PCI host select.
  logic              rstn_q, rstn_d;      // Reset pin seen last cycle.
  logic              hrf_q, hrf_d;        // Host-release flag.
  logic [31:0]       emc_q, emc_d;        // Memory interface configuration.
  logic [5:0]        pwrd_q, pwrd_d;      // Programmed power-down field.
  logic              ack_q, ack_d;        // Host port acknowledge.
  logic [31:0]       rdat_q, rdat_d;      // Host port read data.
  logic              rreq_q, rreq_d;      // ROM request.
  logic [ROM_AW-1:0] raddr_q, raddr_d;    // ROM byte index.
  logic [31:0]       acc_q, acc_d;        // Word being packed.
  logic              start_q, start_d;    // CPU start pulse.
  logic              irq_q, irq_d;        // Interrupt pulse.
  logic              tck_q, tck_d;        // Test clock last level.
  logic              trsts_q, trsts_d;    // Test reset sampled on test clock rise.
  logic [1:0]        ecfg_q, ecfg_d;      // Latched emulation pins.
  logic              vok_q, vok_d;        // Variant field valid.
  logic [31:0]       fetch_q;             // Fetch data register.
  logic [31:0]       mem [MEM_WORDS];     // Internal memory at address 0.
  logic              core_rst;            // Device held in reset.
  logic              hp_take;             // Host access accepted this cycle.
  logic              hp_wmem;             // Host writes the memory array.
  logic              rom_wmem;            // ROM copy writes a packed word.
  logic [31:0]       packed_w;            // Accumulator with the new byte.
  logic              emu_att;             // Emulator attached and out of test reset.
  logic              hrf_set;             // Host sets the release flag.

  // The weak pull-down keeps emulation logic in reset when the host leaves the pin open.
  assign pins.trst_pd = 1'b1;

  // Next-state logic for the whole sequencer.
  always_comb begin
    core_rst = rst_in | ~pins.reset_n;
    st_d = st_q;
    boot_d = boot_q;
    pci_d = pci_q;
    rstn_d = pins.reset_n;
    hrf_d = hrf_q;
    emc_d = emc_q;
    pwrd_d = pwrd_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    rreq_d = rreq_q;
    raddr_d = raddr_q;
    acc_d = acc_q;
    start_d = 1'b0;
    irq_d = 1'b0;
    tck_d = pins.tck;
    trsts_d = trsts_q;
    ecfg_d = ecfg_q;
    vok_d = ~core_rst;
    // Only the strapped port may reach the device, others are acked and ignored.
    hp_take = pins.hp_req & ~ack_q & ~core_rst & (pins.hp_pci == pci_q);
    hp_wmem = hp_take & pins.hp_we & (pins.hp_addr < HP_AW'(MEM_WORDS));
    hrf_set = hp_take & pins.hp_we & (pins.hp_addr == HPC_ADDR) & pins.hp_wdata[HRF_BIT];
    // Byte order follows the system endianness strap.
    packed_w = pins.little_end ? {pins.rom_data, acc_q[31:8]} : {acc_q[23:0], pins.rom_data};
    rom_wmem = (st_q == ST_ROM_COPY) & pins.rom_ack & (raddr_q[1:0] == 2'h3);
    emu_att = trsts_q & pins.cable;
    // Host port: acknowledge any request once, act only on accepted ones.
    if (pins.hp_req & ~ack_q & ~core_rst) begin
      ack_d = 1'b1;
      rdat_d = 32'h0000_0000;
      if (hp_take & ~pins.hp_we) begin
        if (pins.hp_addr < HP_AW'(MEM_WORDS)) begin
          rdat_d = mem[pins.hp_addr[7:0]];
        end else if (pins.hp_addr == HPC_ADDR) begin
          rdat_d = 32'(hrf_q) << HRF_BIT;
        end else if (pins.hp_addr == EMC_ADDR) begin
          rdat_d = emc_q;
        end
      end
      if (hp_take & pins.hp_we & (pins.hp_addr == EMC_ADDR)) begin
        emc_d = pins.hp_wdata;
      end
    end
    // Set wins over the CPU clear so a late host write is never lost.
    if (cpu_flag_clr_in) begin
      hrf_d = 1'b0;
    end
    if (hrf_set) begin
      hrf_d = 1'b1;
    end
    // A new interrupt only from a clear flag and never while stalled.
    if (hrf_set & ~hrf_q & (st_q == ST_RUN)) begin
      irq_d = 1'b1;
    end
    if (pwrd_wr_in) begin
      pwrd_d = pwrd_in;
    end
    // Test reset is only looked at on rising test clock edges.
    if (pins.tck & ~tck_q) begin
      trsts_d = pins.trst;
      if (pins.trst & ~trsts_q & ~core_rst) begin
        ecfg_d = pins.emu_pins;
      end
    end
    case (st_q)
      ST_RESET: begin
        rreq_d = 1'b0;
        raddr_d = '0;
        // Straps are caught on the pin's rising edge and held until the next reset.
        if (~rstn_q & pins.reset_n) begin
          boot_d = brc_boot_t'(pins.boot_mode);
          pci_d = pins.pci_sel;
        end
        // One cycle after capture the sequencer leaves reset, test reset ignored.
        if (~core_rst & rstn_q) begin
          case (boot_q)
            BRC_BOOT_HOST: st_d = ST_HOST_STALL;
            BRC_BOOT_ROM: begin
              st_d = ST_ROM_COPY;
              rreq_d = 1'b1;
            end
            default: begin
              st_d = ST_RUN;
              start_d = 1'b1;
            end
          endcase
        end
      end
      ST_HOST_STALL: begin
        // Only reachable in host boot, so the flag releases nothing elsewhere.
        if (hrf_set) begin
          st_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_ROM_COPY: begin
        if (pins.rom_ack) begin
          acc_d = packed_w;
          raddr_d = raddr_q + 1'b1;
          // One frame of the whole image, then release the CPU.
          if (raddr_q == ROM_LAST) begin
            rreq_d = 1'b0;
            st_d = ST_RUN;
            start_d = 1'b1;
          end
        end
      end
      ST_RUN: begin
        // Masking is dropped when the emulator is reset or unplugged.
        if (~emu_att & ((pwrd_q == PWRD_CLKOUT_HALT) | (pwrd_q == PWRD_CLKIN_HALT))) begin
          st_d = ST_HALT;
        end
      end
      ST_HALT: st_d = ST_HALT;
      default: st_d = ST_RESET;
    endcase
    // Device reset overrides state, flag, memory config, power-down field and ROM request, and is the only halt exit.
    if (core_rst) begin
      st_d = ST_RESET;
      hrf_d = 1'b0;
      emc_d = EMC_RESET;
      pwrd_d = 6'h00;
      rreq_d = 1'b0;
      start_d = 1'b0;
    end
    if (rst_in) begin
      boot_d = BRC_BOOT_NONE;
      pci_d = 1'b0;
      trsts_d = 1'b0;
      ecfg_d = EMU_CFG_RESET;
    end
  end

  // State registers.
  always_ff @(posedge clock_in) begin
    st_q <= st_d;
    boot_q <= boot_d;
    pci_q <= pci_d;
    rstn_q <= rst_in ? 1'b0 : rstn_d;
    hrf_q <= hrf_d;
    emc_q <= emc_d;
    pwrd_q <= pwrd_d;
    ack_q <= rst_in ? 1'b0 : ack_d;
    rdat_q <= rst_in ? 32'h0000_0000 : rdat_d;
    rreq_q <= rreq_d;
    raddr_q <= raddr_d;
    acc_q <= rst_in ? 32'h0000_0000 : acc_d;
    start_q <= start_d;
    irq_q <= irq_d;
    tck_q <= rst_in ? 1'b0 : tck_d;
    trsts_q <= trsts_d;
    ecfg_q <= ecfg_d;
    vok_q <= rst_in ? 1'b0 : vok_d;
  end

  // Memory array: host writes and packed ROM words; contents survive device reset.
  always_ff @(posedge clock_in) begin
    if (hp_wmem) begin
      mem[pins.hp_addr[7:0]] <= pins.hp_wdata;
    end else if (rom_wmem) begin
      mem[raddr_q[9:2]] <= packed_w;
    end
    fetch_q <= rst_in ? 32'h0000_0000 : mem[cpu_fetch_addr_in];
  end

  assign pins.hp_ack = ack_q;
  assign pins.hp_rdata = rdat_q;
  assign pins.rom_req = rreq_q;
  assign pins.rom_addr = raddr_q;
  assign cpu_stall_out = (st_q != ST_RUN) & (st_q != ST_HALT);
  assign cpu_start_out = start_q;
  assign cpu_start_pc_out = BOOT_PC;
  assign cpu_fetch_data_out = fetch_q;
  assign cpu_hrf_irq_out = irq_q;
  assign hrf_out = hrf_q;
  assign pwrd_eff_out = emu_att ? 6'h00 : pwrd_q;
  assign halted_out = (st_q == ST_HALT);
  // In a deep halt commands spin and PC writes are refused.
  assign emu_spin_out = (st_q == ST_HALT) & emu_cmd_in;
  assign emu_pc_ok_out = (st_q != ST_HALT) & emu_pc_wr_in;
  assign variant_ok_out = vok_q;
  assign emu_cfg_out = ecfg_q;
  assign bscan_mode_out = (ecfg_q == EMU_CFG_BSCAN);
  assign emc_cfg_out = emc_q;
endmodule // brc_device
`default_nettype wire

// ### rtl/brc_host.sv
// Purpose: Host end: resets, straps, test clock, host port master and boot ROM.
// Assumes: User logic loads the ROM image in the system byte order.
// Notes:   One host access is outstanding at a time.
`timescale 1ns/1ps
`default_nettype none
module brc_host
  import brc_pkg::*;
(
  input  wire logic              clock_in,        // System clock.
  input  wire logic              rst_in,          // Power-on reset, active high.
  brc_if.host                    pins,            // Link to the device end.
  input  wire logic              dev_reset_in,    // Hold the device in reset.
  input  wire logic              trst_assert_in,  // Hold the test logic in reset.
  input  wire logic [1:0]        boot_mode_in,    // Boot mode straps.
  input  wire logic              pci_sel_in,      // PCI host select strap.
  input  wire logic              little_end_in,   // Endianness strap.
  input  wire logic [1:0]        emu_pins_in,     // Emulation configuration pins.
  input  wire logic              cable_in,        // Emulator cable present.
  input  wire logic              cmd_valid_in,    // Host access request.
  input  wire logic              cmd_we_in,       // Access is a write.
  input  wire logic [HP_AW-1:0]  cmd_addr_in,     // Word address.
  input  wire logic [31:0]       cmd_wdata_in,    // Write data.
  output logic                   cmd_ready_out,   // Request accepted when high with valid.
  output logic                   rsp_valid_out,   // Pulse: access finished.
  output logic [31:0]            rsp_rdata_out,   // Read data.
  input  wire logic              rom_wr_in,       // Load one ROM byte.
  input  wire logic [ROM_AW-1:0] rom_waddr_in,    // ROM byte address.
  input  wire logic [7:0]        rom_wdata_in     // ROM byte.
);
  import brc_pkg::*;

  logic [7:0]        rom [ROM_BYTES];     // Boot ROM image.
  logic [7:0]        div_q, div_d;        // Test clock divider.
  logic              tck_q, tck_d;        // Test clock level.
  logic              rstn_q, rstn_d;      // Device reset drive.
  logic              toe_q, toe_d;        // Test reset drive enable.
  logic              req_q, req_d;        // Host port request.
  logic              we_q, we_d;          // Latched write flag.
  logic [HP_AW-1:0]  addr_q, addr_d;      // Latched address.
  logic [31:0]       wdat_q, wdat_d;      // Latched write data.
  logic              rsp_q, rsp_d;        // Response pulse.
  logic [31:0]       rdat_q, rdat_d;      // Response data.
  logic              rack_q, rack_d;      // ROM acknowledge.
  logic [7:0]        rbyte_q;             // ROM byte out.

  // Next values: the test clock runs always so test reset is seen while asserted.
  always_comb begin
    div_d = div_q + 8'h01;
    tck_d = tck_q;
    if (div_q == 8'(TCK_DIV - 1)) begin
      div_d = 8'h00;
      tck_d = ~tck_q;
    end
    // Both resets are asserted from power up; test reset is left to the pull-down.
    rstn_d = ~dev_reset_in;
    toe_d = ~trst_assert_in;
    req_d = req_q;
    we_d = we_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rsp_d = 1'b0;
    rdat_d = rdat_q;
    if (req_q & pins.hp_ack) begin
      req_d = 1'b0;
      rsp_d = 1'b1;
      rdat_d = pins.hp_rdata;
    end else if (~req_q & cmd_valid_in) begin
      req_d = 1'b1;
      we_d = cmd_we_in;
      addr_d = cmd_addr_in;
      wdat_d = cmd_wdata_in;
    end
    rack_d = pins.rom_req & ~rack_q;
  end

  // Registers.
  always_ff @(posedge clock_in) begin
    div_q <= rst_in ? 8'h00 : div_d;
    tck_q <= rst_in ? 1'b0 : tck_d;
    rstn_q <= rst_in ? 1'b0 : rstn_d;
    toe_q <= rst_in ? 1'b0 : toe_d;
    req_q <= rst_in ? 1'b0 : req_d;
    we_q <= rst_in ? 1'b0 : we_d;
    addr_q <= rst_in ? '0 : addr_d;
    wdat_q <= rst_in ? 32'h0000_0000 : wdat_d;
    rsp_q <= rst_in ? 1'b0 : rsp_d;
    rdat_q <= rst_in ? 32'h0000_0000 : rdat_d;
    rack_q <= rst_in ? 1'b0 : rack_d;
  end

  // ROM array: the image must already be in the system's byte order.
  always_ff @(posedge clock_in) begin
    if (rom_wr_in) begin
      rom[rom_waddr_in] <= rom_wdata_in;
    end
    rbyte_q <= rom[pins.rom_addr];
  end

  assign pins.reset_n = rstn_q;
  assign pins.trst_drv = 1'b1;
  assign pins.trst_oe = toe_q;
  assign pins.tck = tck_q;
  assign pins.boot_mode = boot_mode_in;
  assign pins.pci_sel = pci_sel_in;
  assign pins.little_end = little_end_in;
  assign pins.emu_pins = emu_pins_in;
  assign pins.cable = cable_in;
  assign pins.hp_req = req_q;
  assign pins.hp_pci = pci_sel_in;
  assign pins.hp_we = we_q;
  assign pins.hp_addr = addr_q;
  assign pins.hp_wdata = wdat_q;
  assign pins.rom_data = rbyte_q;
  assign pins.rom_ack = rack_q;
  assign cmd_ready_out = ~req_q;
  assign rsp_valid_out = rsp_q;
  assign rsp_rdata_out = rdat_q;
endmodule // brc_host
`default_nettype wire

// ### test/brc_chk.sv
// Purpose: Checks the wire between the device end and the host end.
// Assumes: One clock; rst_in resets both ends.
// Notes:   Sees only interface signals, so user-side rules live in the bench.
`timescale 1ns/1ps
`default_nettype none
module brc_chk
  import brc_pkg::*;
(
  input  wire logic              clock_in,  // Shared clock.
  input  wire logic              rst_in,    // Power-on reset.
  input  wire logic              reset_n,   // Device reset pin.
  input  wire logic              trst_oe,   // Host drives test reset.
  input  wire logic              trst,      // Resolved test reset.
  input  wire logic              hp_req,    // Host request.
  input  wire logic              hp_ack,    // Device acknowledge.
  input  wire logic              rom_req,   // ROM byte request.
  input  wire logic              rom_ack,   // ROM byte valid.
  input  wire logic [ROM_AW-1:0] rom_addr   // ROM byte index.
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Reset must have been off for two edges, though the pin gates the device ack in the same cycle.
  sequence s_take; hp_req && !hp_ack && reset_n && $past(reset_n); endsequence
  sequence s_byte; rom_req && !rom_ack && reset_n; endsequence
  property p_ack_next; s_take |=> hp_ack; endproperty
  property p_ack_pulse; hp_ack |=> !hp_ack; endproperty
  property p_quiet; !reset_n ##1 !reset_n |-> !rom_req && !hp_ack; endproperty
  property p_pull; !trst_oe |-> !trst; endproperty
  property p_rom_next; s_byte |=> rom_ack; endproperty
  property p_rom_hold; s_byte |=> $stable(rom_addr); endproperty
  property p_rom_pulse; rom_ack |=> !rom_ack; endproperty
  property p_rom_cause; rom_ack |-> $past(rom_req); endproperty
  a_ack_next: assert property (p_ack_next) else $error("host ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("host ack too long");
  a_quiet: assert property (p_quiet) else $error("activity in reset");
  a_pull: assert property (p_pull) else $error("test reset not pulled low");
  a_rom_next: assert property (p_rom_next) else $error("rom byte late");
  a_rom_hold: assert property (p_rom_hold) else $error("rom address moved");
  a_rom_pulse: assert property (p_rom_pulse) else $error("rom ack too long");
  a_rom_cause: assert property (p_rom_cause) else $error("rom ack unasked");
endmodule // brc_chk
`default_nettype wire

// ### test/boot_reset_configuration_tb.sv
// Purpose: Boots the device through the host end in every mode.
// Assumes: Both ends share clock_in at 25 MHz.
// Notes:   ROM image after its first four bytes and host data are random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module boot_reset_configuration_tb;
  import brc_pkg::*;
  localparam logic [31:0] FLAG = 32'h1 << HRF_BIT; // Host-release flag word.
  logic        clock_in, rst_in, dev_rst, trst_a, pci, le, cable, valid, we, rw, clr, pw, cmd;
  logic        pcw, stall, start, irq, hrf, halted, spin, pc_ok, var_ok, rsp, bscan;
  logic [1:0]  mode, emu, cfg;
  logic [5:0]  pwr, peff;
  logic [7:0]  fadr, pc, rom [ROM_BYTES];
  logic [9:0]  adr, a;
  logic [31:0] wd, rd, d, fdata, rdata, emc;
  int          num_errors = 0, total_checks = 0, cyc = 0, starts = 0, irqs = 0, n;
  brc_if i_brc_if ();
  brc_host i_brc_host (.clock_in, .rst_in, .pins(i_brc_if.host), .dev_reset_in(dev_rst),
    .trst_assert_in(trst_a), .boot_mode_in(mode), .pci_sel_in(pci), .little_end_in(le),
    .emu_pins_in(emu), .cable_in(cable), .cmd_valid_in(valid), .cmd_we_in(we),
    .cmd_addr_in(adr), .cmd_wdata_in(wd), .cmd_ready_out(), .rsp_valid_out(rsp),
    .rsp_rdata_out(rdata), .rom_wr_in(rw), .rom_waddr_in(adr), .rom_wdata_in(wd[7:0]));
  brc_device i_brc_device (.clock_in, .rst_in, .pins(i_brc_if.dev), .cpu_flag_clr_in(clr),
    .pwrd_wr_in(pw), .pwrd_in(pwr), .emu_cmd_in(cmd), .emu_pc_wr_in(pcw),
    .cpu_fetch_addr_in(fadr), .cpu_stall_out(stall), .cpu_start_out(start),
    .cpu_start_pc_out(pc), .cpu_fetch_data_out(fdata), .cpu_hrf_irq_out(irq), .hrf_out(hrf),
    .pwrd_eff_out(peff), .halted_out(halted), .emu_spin_out(spin), .emu_pc_ok_out(pc_ok),
    .variant_ok_out(var_ok), .emu_cfg_out(cfg), .bscan_mode_out(bscan), .emc_cfg_out(emc));
  brc_chk i_brc_chk (.clock_in, .rst_in, .reset_n(i_brc_if.reset_n),
    .trst_oe(i_brc_if.trst_oe), .trst(i_brc_if.trst), .hp_req(i_brc_if.hp_req),
    .hp_ack(i_brc_if.hp_ack), .rom_req(i_brc_if.rom_req), .rom_ack(i_brc_if.rom_ack),
    .rom_addr(i_brc_if.rom_addr));
  always #20 clock_in = ~clock_in;
  // Count one-cycle pulses so that none is missed between checks.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    starts <= starts + int'(start === 1'b1);
    irqs <= irqs + int'(irq === 1'b1);
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  task automatic acc(input logic w, input logic [9:0] ad, input logic [31:0] dt);
    {we, adr, wd, valid} = {w, ad, dt, 1'b1};
    tick(1);
    valid = 1'b0;
    for (n = 0; n < 300 && rsp !== 1'b1; n++) tick(1);
    rd = rdata;
  endtask
  task automatic boot(input logic [1:0] m);
    {dev_rst, mode, pci} = {1'b1, m, 1'($urandom)};
    tick(4);
    dev_rst = 1'b0;
    tick(8);
  endtask
  task automatic wait_start(input int t);
    for (n = 0; n < 3000 && starts < t; n++) tick(1);
    chk(32'(starts), 32'(t));
  endtask
  // Packing of four ROM bytes into one word in the chosen byte order.
  function automatic logic [31:0] word(input int k);
    if (le) return {rom[4*k+3], rom[4*k+2], rom[4*k+1], rom[4*k]};
    return {rom[4*k], rom[4*k+1], rom[4*k+2], rom[4*k+3]};
  endfunction
  initial begin
    {clock_in, rst_in, dev_rst, trst_a, cable, valid, we, rw, clr, pw, cmd, pcw} = 12'h700;
    {pci, le, mode, emu, pwr, fadr, adr, wd} = '0;
    void'($urandom(32'h6E4A3DD4));
    tick(12);
    rst_in = 1'b0;
    for (int i = 0; i < ROM_BYTES; i++) begin
      rom[i] = (i < 4) ? 8'hFF : 8'($urandom);
      {rw, adr, wd} = {1'b1, 10'(i), 24'h0, rom[i]};
      tick(1);
    end
    {rw, le} = {1'b0, 1'($urandom)};
    boot(BRC_BOOT_ROM);
    chk1(stall, 1'b1);
    acc(1'b1, HPC_ADDR, FLAG);
    chk1(stall, 1'b1);
    wait_start(1);
    chk1(stall, 1'b0);
    chk({24'h0, pc}, {24'h0, BOOT_PC});
    for (int k = 0; k < 6; k++) begin
      fadr = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
      tick(2);
      chk(fdata, word(fadr));
    end
    boot(BRC_BOOT_HOST);
    {a, d, irqs} = {10'($urandom % MEM_WORDS), $urandom, 32'h0};
    chk1(stall, 1'b1);
    acc(1'b1, a, d);
    acc(1'b0, a, 32'h0);
    chk(rd, d);
    acc(1'b1, EMC_ADDR, d);
    chk(emc, d);
    acc(1'b1, HPC_ADDR, FLAG);
    wait_start(2);
    chk1(stall, 1'b0);
    chk1(hrf, 1'b1);
    chk(32'(irqs), 32'h0);
    acc(1'b1, HPC_ADDR, FLAG);
    chk(32'(irqs), 32'h0);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    acc(1'b1, HPC_ADDR, FLAG);
    chk(32'(irqs), 32'h1);
    pci = ~pci;
    acc(1'b0, a, 32'h0);
    chk(rd, 32'h0);
    {emu, cable} = {2'($urandom), 1'b1};
    boot(BRC_BOOT_NONE);
    chk1(stall, 1'b0);
    chk1(var_ok, 1'b1);
    chk({30'h0, cfg}, {30'h0, EMU_CFG_RESET});
    trst_a = 1'b0;
    tick(24);
    chk({30'h0, cfg}, {30'h0, emu});
    chk1(bscan, emu == EMU_CFG_BSCAN);
    {pwr, pw} = {($urandom % 2) ? PWRD_CLKOUT_HALT : PWRD_CLKIN_HALT, 1'b1};
    tick(1);
    pw = 1'b0;
    tick(3);
    chk1(halted, 1'b0);
    chk({26'h0, peff}, 32'h0);
    cable = 1'b0;
    tick(4);
    chk1(halted, 1'b1);
    {cmd, pcw} = 2'h3;
    tick(1);
    chk1(spin, 1'b1);
    chk1(pc_ok, 1'b0);
    boot(BRC_BOOT_RSVD);
    chk1(halted, 1'b0);
    conclude();
  end
endmodule // boot_reset_configuration_tb
`default_nettype wire
